/* File: rtl/cti_pkg.sv */
package cti_pkg;
  localparam int NCH = 4;
  localparam int NFLT = 2;
  localparam int NIRQ = 16;
  localparam logic [7:0] OFF_TIMER_CONTROL_A = 8'h00;
  localparam logic [7:0] OFF_TIMER_CONTROL_B = 8'h04;
  localparam logic [7:0] OFF_EVENT_CONTROL_REG = 8'h20;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h24;
  localparam logic [7:0] OFF_IRQ_SET = 8'h28;
  localparam logic [7:0] OFF_IRQ_FLAG = 8'h2c;
  localparam logic [7:0] OFF_STATUS = 8'h30;
  localparam int CA_SOFTWARE_RESET_BIT = 0;
  localparam int CA_ENABLE = 1;
  localparam int CA_AUTO_LOCK_UPDATE = 14;
  localparam int CA_CPTEN = 24;
  localparam logic [31:0] TIMER_CONTROL_A_RESET = 32'h00000000;
  localparam logic [31:0] TIMER_CONTROL_A_MASK = 32'h0f007f63;
  localparam int CB_LOCK_UPDATE_BIT = 1;
  localparam int EV_COUNT_EVENT_SELECT = 6;
  localparam int EV_EVACT1 = 3;
  localparam int EV_WRAP_EVENT_OUTPUT_ENABLE = 8;
  localparam int EV_RETRIGGER_EVENT_OUTPUT_ENABLE = 9;
  localparam int EV_COUNT_EVENT_OUTPUT_ENABLE = 10;
  localparam int EV_MCEO = 24;
  localparam logic [31:0] EVENT_CONTROL_REG_MASK = 32'h0f0007f8;
  localparam int IF_WRAP = 0;
  localparam int IF_TRG = 1;
  localparam int IF_CNT = 2;
  localparam int IF_ERR = 3;
  localparam int IF_DFS = 11;
  localparam int IF_RFLT = 12;
  localparam int IF_NFLT = 14;
  localparam int IF_MC = 16;
  localparam logic [31:0] IRQ_MASK = 32'h000ff80f;
  localparam logic [1:0] COUNT_EVENT_SELECT_START = 2'h0;
  localparam logic [1:0] COUNT_EVENT_SELECT_END = 2'h1;
  localparam logic [1:0] COUNT_EVENT_SELECT_BOTH = 2'h3;
  localparam logic [1:0] EVACT_RETRIG = 2'h1;
  localparam logic [1:0] EVACT_DIR = 2'h2;
  localparam logic [1:0] EVACT_STOP = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int SYNC_CYCLES = 2;
  typedef enum {CTI_IDLE, CTI_WRESP, CTI_RRESP} cti_bus_e;
endpackage

/* File: rtl/cti_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module cti_sync #(parameter int W = 1) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstN,
  // crossing
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] metaReg;
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      metaReg <= '0;
      dout <= '0;
    end else begin
      metaReg <= din;
      dout <= metaReg;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/cti_control_timer.sv */
// Functional notes
// RL1 - interrupt sources: wrap, retrigger, cycle, error, faults, channels
// RL2 - any flag raises an unclocked wake request (code: wakeReq is the registered irqReq, so only enabled flags raise it)
// RL3 - each condition sets its own flag
// RL4 - set register enables, clear register disables
// RL5 - request only when flag and enable set
// RL6 - request holds until flag, enable, reset cleared
// RL7 - all enabled pending flags ORed onto one line
// RL8 - software reads flag register to find cause
// RL9 - output events for wrap, trigger, cycle, channels
// RL10 - each output event gated by its enable bit
// RL11 - channel event captures or raises a fault
// RL12 - counter event one retriggers, steers, or stops
// RL13 - control A at zero, protected while enabled
// RL14 - bits 24..27 select capture per channel
// RL15 - auto lock sets lock update on wrap/retrigger
// RL16 - auto lock acts without write synchronisation
// RL17 - wrap event at top or zero
// RL18 - cycle event at start or end per select
// RL19 - retrigger event on every retrigger
// RL20 - software reset clears all, reads one meanwhile
// RL21 - writing one clears a flag, request follows
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cti_control_timer (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // counter conditions, one-cycle pulses from the counting core
  input wire logic atTop,
  input wire logic atZero,
  input wire logic cycleStart,
  input wire logic cycleEnd,
  input wire logic [cti_pkg::NCH-1:0] chanMatch,
  input wire logic captureOverrun,
  input wire logic debugFault,
  // input events from the event system, asynchronous levels
  input wire logic [cti_pkg::NCH-1:0] chanEventIn,
  input wire logic counterEventOne,
  // config for channel events: 0 capture, 1 recoverable, 2+ nonrecoverable
  input wire logic [1:0] chanEventAction,
  // requests and events
  output logic irqReq,
  output logic wakeReq,
  output logic wrapEventOut,
  output logic retriggerEventOut,
  output logic countEventOut,
  output logic [cti_pkg::NCH-1:0] chanEventOut,
  output logic [cti_pkg::NCH-1:0] captureStrobe,
  output logic counterRetrigger,
  output logic counterDown,
  output logic counterStop,
  output logic timerEnabled
);
  import cti_pkg::*;

  typedef struct packed {
    cti_bus_e bus;
    logic awready;
    logic wready;
    logic [7:0] wAddr;
    logic haveAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic haveData;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic [31:0] timer_control_a;
    logic [31:0] timer_control_b;
    logic [31:0] event_control_reg;
    logic [31:0] irqEn;
    logic [31:0] irqFlag;
    logic [SYNC_CYCLES-1:0] enPipe;
    logic [SYNC_CYCLES-1:0] rstPipe;
    logic enabled;
    logic irqReq;
    logic wrapEv;
    logic trgEv;
    logic cntEv;
    logic [NCH-1:0] chEv;
    logic [NCH-1:0] cap;
    logic retrig;
    logic down;
    logic stop;
    logic [NCH-1:0] chEvPrev;
    logic ev1Prev;
  } cti_state_s;

  cti_state_s stateReg;
  cti_state_s stateNext;
  logic rstSync0;
  logic rstSync1;
  logic [NCH-1:0] chEvSync;
  logic ev1Sync;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstSync0 <= 1'b0;
      rstSync1 <= 1'b0;
    end else begin
      rstSync0 <= 1'b1;
      rstSync1 <= rstSync0;
    end
  end

  cti_sync #(.W(NCH + 1)) u_evsync (
    .clk_sys(clk_sys),
    .rstN(rstSync1),
    .din({counterEventOne, chanEventIn}),
    .dout({ev1Sync, chEvSync})
  );

  logic [NCH-1:0] chRise;
  logic ev1Rise;
  logic retrigNow;
  logic wrapNow;
  logic recFault;
  logic nrecFault;
  logic [31:0] setMask;
  logic [31:0] wrMask;
  logic [31:0] wrVal;
  logic [31:0] rdVal;
  logic doWrite;
  logic swReset;

  always_comb begin
    stateNext = stateReg;
    chRise = chEvSync & ~stateReg.chEvPrev;
    ev1Rise = ev1Sync & ~stateReg.ev1Prev;
    stateNext.chEvPrev = chEvSync;
    stateNext.ev1Prev = ev1Sync;
    wrMask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
    wrVal = '0;
    rdVal = '0;
    doWrite = 1'b0;
    swReset = 1'b0;
    recFault = 1'b0;
    nrecFault = 1'b0;

    // counter event one actions; retrigger and stop only while running, direction always
    retrigNow = ev1Rise && stateReg.enabled
      && stateReg.event_control_reg[EV_EVACT1 +: 2] == EVACT_RETRIG; // see RL12
    stateNext.retrig = retrigNow;
    stateNext.stop = ev1Rise && stateReg.enabled
      && stateReg.event_control_reg[EV_EVACT1 +: 2] == EVACT_STOP; // see RL12
    if (stateReg.event_control_reg[EV_EVACT1 +: 2] == EVACT_DIR) begin
      stateNext.down = ev1Sync; // see RL12
    end else begin
      stateNext.down = 1'b0;
    end

    // channel input events capture or fault
    stateNext.cap = '0;
    for (int i = 0; i < NCH; i++) begin
      if (chRise[i] && stateReg.enabled) begin
        if (chanEventAction == 2'h0 && stateReg.timer_control_a[CA_CPTEN + i]) begin
          stateNext.cap[i] = 1'b1; // see RL11 see RL14
        end else if (chanEventAction == 2'h1) begin
          recFault = 1'b1; // see RL11
        end else if (chanEventAction[1]) begin
          nrecFault = 1'b1; // see RL11
        end
      end
    end

    wrapNow = stateReg.enabled && (atTop || atZero);
    // output events gated by their enables
    stateNext.wrapEv = wrapNow && stateReg.event_control_reg[EV_WRAP_EVENT_OUTPUT_ENABLE]; // see RL9 see RL10 see RL17
    stateNext.trgEv = retrigNow && stateReg.event_control_reg[EV_RETRIGGER_EVENT_OUTPUT_ENABLE]; // see RL19 see RL10
    case (stateReg.event_control_reg[EV_COUNT_EVENT_SELECT +: 2])
      COUNT_EVENT_SELECT_START: stateNext.cntEv = cycleStart;
      COUNT_EVENT_SELECT_END: stateNext.cntEv = cycleEnd;
      COUNT_EVENT_SELECT_BOTH: stateNext.cntEv = cycleStart || cycleEnd;
      default: stateNext.cntEv = 1'b0;
    endcase
    stateNext.cntEv = stateNext.cntEv && stateReg.enabled
      && stateReg.event_control_reg[EV_COUNT_EVENT_OUTPUT_ENABLE]; // see RL18 see RL10
    stateNext.chEv = stateReg.enabled ? chanMatch & stateReg.event_control_reg[EV_MCEO +: NCH]
      : '0; // see RL9 see RL10

    // flag set sources
    setMask = '0;
    setMask[IF_WRAP] = wrapNow; // see RL1 see RL3
    setMask[IF_TRG] = retrigNow;
    setMask[IF_CNT] = stateReg.enabled && (cycleStart || cycleEnd);
    setMask[IF_ERR] = captureOverrun;
    setMask[IF_DFS] = debugFault;
    setMask[IF_RFLT] = recFault;
    setMask[IF_NFLT] = nrecFault;
    setMask[IF_MC +: NCH] = stateReg.enabled ? (chanMatch | stateNext.cap) : '0;

    // write synchronisation of enable and software reset
    stateNext.enPipe = {stateReg.enPipe[SYNC_CYCLES-2:0], stateReg.timer_control_a[CA_ENABLE]};
    stateNext.rstPipe = {stateReg.rstPipe[SYNC_CYCLES-2:0], stateReg.timer_control_a[CA_SOFTWARE_RESET_BIT]};
    stateNext.enabled = stateReg.enPipe[SYNC_CYCLES-1]; // see RL13
    swReset = stateReg.rstPipe[SYNC_CYCLES-1];

    // bus handshakes
    stateNext.awready = 1'b0;
    stateNext.wready = 1'b0;
    stateNext.arready = 1'b0;
    if (awvalid && stateReg.awready) begin
      stateNext.wAddr = awaddr;
      stateNext.haveAddr = 1'b1;
    end
    if (wvalid && stateReg.wready) begin
      stateNext.wData = wdata;
      stateNext.wStrb = wstrb;
      stateNext.haveData = 1'b1;
    end
    wrMask = {{8{stateReg.wStrb[3]}}, {8{stateReg.wStrb[2]}},
      {8{stateReg.wStrb[1]}}, {8{stateReg.wStrb[0]}}};
    wrVal = stateReg.wData & wrMask;

    case (stateReg.bus)
      CTI_IDLE: begin
        if (stateReg.haveAddr && stateReg.haveData) begin
          doWrite = 1'b1;
          stateNext.haveAddr = 1'b0;
          stateNext.haveData = 1'b0;
          stateNext.bvalid = 1'b1;
          stateNext.bresp = RESP_OKAY;
          stateNext.bus = CTI_WRESP;
        end else if (arvalid && !stateReg.arready && !stateReg.haveAddr
          && !stateReg.haveData) begin
          stateNext.arready = 1'b1;
          stateNext.rvalid = 1'b1;
          stateNext.rresp = RESP_OKAY;
          case (araddr)
            OFF_TIMER_CONTROL_A: rdVal = stateReg.timer_control_a;
            OFF_TIMER_CONTROL_B: rdVal = stateReg.timer_control_b;
            OFF_EVENT_CONTROL_REG: rdVal = stateReg.event_control_reg;
            OFF_IRQ_CLR: rdVal = stateReg.irqEn;
            OFF_IRQ_SET: rdVal = stateReg.irqEn;
            OFF_IRQ_FLAG: rdVal = stateReg.irqFlag; // see RL8
            OFF_STATUS: rdVal = {31'h0, stateReg.enabled};
            default: stateNext.rresp = RESP_SLVERR;
          endcase
          stateNext.rdata = rdVal;
          stateNext.bus = CTI_RRESP;
        end else begin
          stateNext.awready = !stateReg.haveAddr && awvalid && !stateReg.awready;
          stateNext.wready = !stateReg.haveData && wvalid && !stateReg.wready;
        end
      end
      CTI_WRESP: begin
        if (bready) begin
          stateNext.bvalid = 1'b0;
          stateNext.bus = CTI_IDLE;
        end
      end
      CTI_RRESP: begin
        if (rready) begin
          stateNext.rvalid = 1'b0;
          stateNext.bus = CTI_IDLE;
        end
      end
      default: stateNext.bus = CTI_IDLE;
    endcase

    // register writes; set of a flag wins over its clear
    stateNext.irqFlag = stateReg.irqFlag;
    if (doWrite) begin
      case (stateReg.wAddr)
        OFF_TIMER_CONTROL_A: begin
          if (stateReg.enabled || stateReg.timer_control_a[CA_ENABLE]) begin
            // protected fields frozen while enabled
            stateNext.timer_control_a[CA_ENABLE] = wrVal[CA_ENABLE]; // see RL13
            stateNext.timer_control_a[CA_SOFTWARE_RESET_BIT] = stateReg.timer_control_a[CA_SOFTWARE_RESET_BIT] | wrVal[CA_SOFTWARE_RESET_BIT];
            stateNext.timer_control_a[CA_AUTO_LOCK_UPDATE] = stateReg.wStrb[1] ? wrVal[CA_AUTO_LOCK_UPDATE]
              : stateReg.timer_control_a[CA_AUTO_LOCK_UPDATE];
          end else begin
            stateNext.timer_control_a = ((stateReg.timer_control_a & ~wrMask) | wrVal) & TIMER_CONTROL_A_MASK; // see RL13
            stateNext.timer_control_a[CA_SOFTWARE_RESET_BIT] = stateReg.timer_control_a[CA_SOFTWARE_RESET_BIT] | wrVal[CA_SOFTWARE_RESET_BIT]; // see RL20
          end
        end
        OFF_TIMER_CONTROL_B: stateNext.timer_control_b = (stateReg.timer_control_b & ~wrMask) | wrVal;
        OFF_EVENT_CONTROL_REG: stateNext.event_control_reg = ((stateReg.event_control_reg & ~wrMask) | wrVal) & EVENT_CONTROL_REG_MASK;
        OFF_IRQ_SET: stateNext.irqEn = stateReg.irqEn | (wrVal & IRQ_MASK); // see RL4
        OFF_IRQ_CLR: stateNext.irqEn = stateReg.irqEn & ~wrVal; // see RL4
        OFF_IRQ_FLAG: stateNext.irqFlag = stateReg.irqFlag & ~wrVal; // see RL21
        default: stateNext.irqFlag = stateReg.irqFlag;
      endcase
    end
    stateNext.irqFlag = (stateNext.irqFlag | setMask) & IRQ_MASK; // see RL3

    // auto lock acts on the live bit, not the sync pipe; placed after the
    // register writes so a same-cycle write to control B cannot drop the set
    if (stateReg.timer_control_a[CA_AUTO_LOCK_UPDATE] && (wrapNow || retrigNow)) begin
      stateNext.timer_control_b[CB_LOCK_UPDATE_BIT] = 1'b1; // see RL15 see RL16
    end

    // one shared line from the next state so clears act at once
    stateNext.irqReq = |(stateNext.irqFlag & stateNext.irqEn); // see RL5 see RL6 see RL7 see RL21

    if (swReset) begin
      // software reset returns every register; bus handshake state survives
      stateNext.timer_control_a = TIMER_CONTROL_A_RESET; // see RL20 see RL6
      stateNext.timer_control_b = '0;
      stateNext.event_control_reg = '0;
      stateNext.irqEn = '0;
      stateNext.irqFlag = '0;
      stateNext.enPipe = '0;
      stateNext.rstPipe = '0;
      stateNext.enabled = 1'b0;
      stateNext.irqReq = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync1) begin
    if (!rstSync1) begin
      stateReg <= '{bus: CTI_IDLE, default: '0};
    end else begin
      stateReg <= stateNext;
    end
  end

  // wake request mirrors the registered request level; it stays up while the
  // clock is stopped because flags and enables only change on a clock edge
  assign awready = stateReg.awready;
  assign wready = stateReg.wready;
  assign bresp = stateReg.bresp;
  assign bvalid = stateReg.bvalid;
  assign arready = stateReg.arready;
  assign rdata = stateReg.rdata;
  assign rresp = stateReg.rresp;
  assign rvalid = stateReg.rvalid;
  assign irqReq = stateReg.irqReq;
  assign wakeReq = stateReg.irqReq; // see RL2
  assign wrapEventOut = stateReg.wrapEv;
  assign retriggerEventOut = stateReg.trgEv;
  assign countEventOut = stateReg.cntEv;
  assign chanEventOut = stateReg.chEv;
  assign captureStrobe = stateReg.cap;
  assign counterRetrigger = stateReg.retrig;
  assign counterDown = stateReg.down;
  assign counterStop = stateReg.stop;
  assign timerEnabled = stateReg.enabled;

  a_irq_matches_flags: assert property (@(posedge clk_sys) disable iff (!rstSync1)
    irqReq == |(stateReg.irqFlag & stateReg.irqEn)) else $error("irq not flag and enable"); // see RL5
  a_flag_sets_wrap: assert property (@(posedge clk_sys) disable iff (!rstSync1)
    (stateReg.enabled && atTop && !swReset) |=> stateReg.irqFlag[IF_WRAP])
    else $error("wrap flag not set"); // see RL3
  a_wrap_event_gate: assert property (@(posedge clk_sys) disable iff (!rstSync1)
    wrapEventOut |-> $past(stateReg.event_control_reg[EV_WRAP_EVENT_OUTPUT_ENABLE])) else $error("wrap event ungated"); // see RL10
  a_enable_set_bit: assert property (@(posedge clk_sys) disable iff (!rstSync1)
    (doWrite && stateReg.wAddr == OFF_IRQ_SET && wrVal[IF_MC] && !swReset)
    |=> stateReg.irqEn[IF_MC]) else $error("enable set failed"); // see RL4
  a_flag_clear_bit: assert property (@(posedge clk_sys) disable iff (!rstSync1)
    (doWrite && stateReg.wAddr == OFF_IRQ_FLAG && wrVal[IF_ERR] && !setMask[IF_ERR])
    |=> !stateReg.irqFlag[IF_ERR]) else $error("flag clear failed"); // see RL21
  a_auto_lock_sets: assert property (@(posedge clk_sys) disable iff (!rstSync1)
    (stateReg.timer_control_a[CA_AUTO_LOCK_UPDATE] && wrapNow && !swReset) |=> stateReg.timer_control_b[CB_LOCK_UPDATE_BIT])
    else $error("lock update not set"); // see RL15
  sequence s_enable_written;
    doWrite && stateReg.wAddr == OFF_TIMER_CONTROL_A && wrVal[CA_ENABLE] && !stateReg.timer_control_a[CA_SOFTWARE_RESET_BIT];
  endsequence
  a_enable_sync_delay: assert property (@(posedge clk_sys) disable iff (!rstSync1)
    s_enable_written ##1 stateReg.timer_control_a[CA_ENABLE] [*3] |=> timerEnabled)
    else $error("enable not synced"); // see RL13
  a_swreset_clears: assert property (@(posedge clk_sys) disable iff (!rstSync1)
    swReset |=> (stateReg.irqEn == '0 && stateReg.timer_control_a == TIMER_CONTROL_A_RESET && !irqReq))
    else $error("software reset incomplete"); // see RL20
endmodule
`default_nettype wire

/* File: dv/cti_event_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module cti_event_partner (
  // clock
  input wire logic clk_sys,
  // bench commands: bits 3..0 channel events, bit 4 counter event one
  input wire logic [4:0] evReq,
  // event lines toward the timer
  output logic [cti_pkg::NCH-1:0] chanEventIn,
  output logic counterEventOne,
  // events from the timer
  input wire logic wrapEventOut,
  input wire logic retriggerEventOut,
  input wire logic countEventOut,
  output logic [7:0] eventCount
);
  import cti_pkg::*;
  logic [4:0] lvl = 5'h00;
  // the event system runs off another clock, so levels land between timer edges
  always @(evReq) lvl <= #37 evReq;
  assign chanEventIn = lvl[3:0];
  assign counterEventOne = lvl[4];
  initial eventCount = 8'h00;
  // every one-cycle wrap, retrigger and count output event is taken once by the event channel
  always @(posedge clk_sys) begin
    eventCount <= eventCount + 8'(wrapEventOut) + 8'(retriggerEventOut) + 8'(countEventOut);
  end
endmodule
`default_nettype wire

/* File: dv/cti_control_timer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin numErrors++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module cti_control_timer_bench;
  import cti_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [9:0] cond = 10'h000;
  logic [4:0] evReq = 5'h00;
  logic [1:0] chanEventAction = 2'h0;
  logic [NCH-1:0] chanEventIn, chanEventOut, captureStrobe;
  logic counterEventOne, irqReq, wakeReq, wrapEventOut, retriggerEventOut, countEventOut;
  logic counterRetrigger, counterDown, counterStop, timerEnabled;
  logic [7:0] eventCount, c;
  logic [33:0] expq[$];
  logic [33:0] e;
  logic [31:0] d;
  logic [3:0] m;
  int numErrors = 0;
  int comparisons = 0;
  logic [31:0] fb[6] = '{32'h1, 32'h1, 32'h4, 32'h4, 32'h8, 32'h800};

  cti_control_timer cti_control_timer_inst (
    .clk_sys(clk_sys), .rst_n(rst_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready),
    .atTop(cond[0]), .atZero(cond[1]), .cycleStart(cond[2]), .cycleEnd(cond[3]),
    .captureOverrun(cond[4]), .debugFault(cond[5]), .chanMatch(cond[9:6]),
    .chanEventIn(chanEventIn), .counterEventOne(counterEventOne),
    .chanEventAction(chanEventAction), .irqReq(irqReq), .wakeReq(wakeReq),
    .wrapEventOut(wrapEventOut), .retriggerEventOut(retriggerEventOut),
    .countEventOut(countEventOut), .chanEventOut(chanEventOut),
    .captureStrobe(captureStrobe), .counterRetrigger(counterRetrigger),
    .counterDown(counterDown), .counterStop(counterStop), .timerEnabled(timerEnabled)
  );

  cti_event_partner cti_event_partner_inst (
    .clk_sys(clk_sys), .evReq(evReq), .chanEventIn(chanEventIn),
    .counterEventOne(counterEventOne), .wrapEventOut(wrapEventOut),
    .retriggerEventOut(retriggerEventOut), .countEventOut(countEventOut),
    .eventCount(eventCount)
  );

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, numErrors);
    if (numErrors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // address and data offered together, each dropped on its own ready
  task automatic wr(input logic [7:0] a, input logic [31:0] dv);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= dv;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    if (n >= 100) `CHK("write answer", 1'b1, 1'b0)
  endtask

  // expected word is queued here and judged by the read monitor
  task automatic rd(input logic [7:0] a, input logic [31:0] dv, input logic [1:0] r = RESP_OKAY);
    int n;
    n = 0;
    expq.push_back({r, dv});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    if (n >= 100) `CHK("read answer", 1'b1, 1'b0)
  endtask

  task automatic pls(input logic [9:0] v);
    cond <= v;
    @(posedge clk_sys);
    cond <= 10'h000;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic chk_irq(input logic x);
    @(posedge clk_sys);
    `CHK("irqReq", x, irqReq)
    `CHK("wakeReq", x, wakeReq)
  endtask

  always @(posedge clk_sys) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      if (expq.size() == 0) `CHK("read count", 1'b1, 1'b0)
      else begin
        e = expq.pop_front();
        `CHK("read word", e, {rresp, rdata})
      end
    end
  end

  // whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    numErrors++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'h1210));
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rd(OFF_TIMER_CONTROL_A, TIMER_CONTROL_A_RESET);
    rd(8'h3c, 32'h0, RESP_SLVERR);
    // wrap, cycle and channel conditions only count while running, so enable first
    d = ($urandom() & 32'h0f000000) | 32'h00004000;
    wr(OFF_TIMER_CONTROL_A, d);
    rd(OFF_TIMER_CONTROL_A, d);
    wr(OFF_TIMER_CONTROL_A, d | 32'h2);
    repeat (6) @(posedge clk_sys);
    for (int i = 0; i < 6; i++) begin
      pls(10'h001 << i);
      rd(OFF_IRQ_FLAG, fb[i]);
      wr(OFF_IRQ_FLAG, fb[i]);
      rd(OFF_IRQ_FLAG, 32'h0);
    end
    chk_irq(1'b0);
    m = 4'($urandom()) | 4'h1;
    pls({m, 6'h00});
    rd(OFF_IRQ_FLAG, {12'h000, m, 16'h0000});
    wr(OFF_IRQ_SET, {12'h000, m, 16'h0000});
    chk_irq(1'b1);
    wr(OFF_IRQ_CLR, {12'h000, m, 16'h0000});
    chk_irq(1'b0);
    wr(OFF_IRQ_SET, {12'h000, m, 16'h0000});
    chk_irq(1'b1);
    wr(OFF_IRQ_FLAG, {12'h000, m, 16'h0000});
    chk_irq(1'b0);
    wr(OFF_EVENT_CONTROL_REG, 32'h0);
    c = eventCount;
    pls(10'h001);
    `CHK("eventCount", c, eventCount)
    wr(OFF_EVENT_CONTROL_REG, 32'h748);
    pls(10'h001);
    `CHK("eventCount", c + 8'h1, eventCount)
    pls(10'h008);
    pls(10'h004);
    `CHK("eventCount", c + 8'h2, eventCount)
    rd(OFF_TIMER_CONTROL_B, 32'h2);
    wr(OFF_IRQ_FLAG, 32'hffffffff);
    evReq <= 5'h10;
    repeat (8) @(posedge clk_sys);
    evReq <= 5'h00;
    repeat (8) @(posedge clk_sys);
    `CHK("eventCount", c + 8'h3, eventCount)
    rd(OFF_IRQ_FLAG, 32'h2);
    wr(OFF_TIMER_CONTROL_A, d | 32'h2);
    repeat (6) @(posedge clk_sys);
    wr(OFF_TIMER_CONTROL_A, 32'h4002);
    repeat (6) @(posedge clk_sys);
    rd(OFF_TIMER_CONTROL_A, d | 32'h2);
    rd(OFF_STATUS, 32'h1);
    `CHK("timerEnabled", 1'b1, timerEnabled)
    wr(OFF_TIMER_CONTROL_A, 32'h1);
    repeat (8) @(posedge clk_sys);
    rd(OFF_TIMER_CONTROL_A, 32'h0);
    rd(OFF_TIMER_CONTROL_B, 32'h0);
    rd(OFF_EVENT_CONTROL_REG, 32'h0);
    `CHK("timerEnabled", 1'b0, timerEnabled)
    repeat (2) @(posedge clk_sys);
    `CHK("pending reads", 0, expq.size())
    tally_and_finish();
  end
endmodule
`default_nettype wire
